/* pkg/cbs_pkg.sv */
package cbs_pkg;
	// cycle status codes {code_or_int_ack, mem_io, status_hi, status_lo}
	localparam logic [3:0] CODE_INT_ACK = 4'h0;
	localparam logic [3:0] CODE_IDLE_3 = 4'h3;
	localparam logic [3:0] CODE_HALT = 4'h4;
	localparam logic [3:0] CODE_MEM_READ = 4'h5;
	localparam logic [3:0] CODE_MEM_WRITE = 4'h6;
	localparam logic [3:0] CODE_IO_READ = 4'h9;
	localparam logic [3:0] CODE_IO_WRITE = 4'ha;
	localparam logic [3:0] CODE_FETCH = 4'hd;
	localparam logic [3:0] CODE_IDLE_F = 4'hf;
	// request kinds
	localparam logic [2:0] REQ_INT_ACK = 3'h0;
	localparam logic [2:0] REQ_HALT = 3'h1;
	localparam logic [2:0] REQ_MEM_READ = 3'h2;
	localparam logic [2:0] REQ_MEM_WRITE = 3'h3;
	localparam logic [2:0] REQ_IO_READ = 3'h4;
	localparam logic [2:0] REQ_IO_WRITE = 3'h5;
	localparam logic [2:0] REQ_FETCH = 3'h6;
	localparam logic [2:0] REQ_SHUTDOWN = 3'h7;
	// reset values of the pin drivers
	localparam logic RST_MEM_IO = 1'b0;
	localparam logic RST_CODE = 1'b0;
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {CBS_IDLE, CBS_STATUS, CBS_COMMAND, CBS_HELD} cbs_state_e;
endpackage : cbs_pkg

/* verilog/cbs_sync.sv */
`timescale 1ns/1ps
module cbs_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// pin in, filtered level out
	input wire logic i_pin,
	output logic o_level
);
	typedef struct packed {
		logic [cbs_pkg::SYNC_STAGES-1:0] chain;
		logic level;
	} cbs_sync_s;
	cbs_sync_s st, next_st;
	always_comb begin
		next_st = st;
		next_st.chain = {st.chain[cbs_pkg::SYNC_STAGES-2:0], i_pin};
		// stage one only feeds stage two; stages two and three must agree
		if (st.chain[1] == st.chain[2]) begin
			next_st.level = st.chain[2];
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_level = st.level;
endmodule : cbs_sync

/* verilog/cbs_bus_cycle.sv */
`timescale 1ns/1ps
// Summary of operation
// - status state encodes cycle type on four lines
// - halt when address bit one high, else shutdown
// - status state means either status line low
// - status lines float high while bus granted
// - memory/io high for memory and halt
// - memory/io floats, keeping last level, when granted
// - code line splits fetch/read and intack/io
// - code line timed like memory/io, holds level
// - lock bars other masters this and next cycle
// - lock on prefix, exchange, intack, descriptor access
// - lock floats high while bus granted
// - cycle lasts until ready sampled low
// - ready is synchronous active-low input
// - ready ignored while bus granted away
// - float drivers first, then raise grant ack
module cbs_bus_cycle (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// core request side
	input wire logic i_req,
	input wire logic [2:0] i_req_kind,
	input wire logic i_lock_prefix,
	input wire logic i_exchange_instruction,
	input wire logic i_descriptor_access,
	output logic o_req_done,
	// bus pins
	input wire logic i_ready_n,
	input wire logic i_hold_req,
	output logic o_cycle_status_hi,
	output logic o_cycle_status_lo,
	output logic o_cycle_status_oe,
	output logic o_mem_io,
	output logic o_code_or_int_ack,
	output logic o_mem_io_code_oe,
	output logic o_lock_n,
	output logic o_lock_oe,
	output logic o_address_bit_one,
	output logic o_status_state,
	output logic o_bus_grant_ack
);
	typedef struct packed {
		cbs_pkg::cbs_state_e state;
		logic [3:0] code;
		logic mem_io;
		logic cod;
		logic a1;
		logic lock_n;
		logic lock_next;
		logic oe;
		logic grant_ack;
		logic done;
	} cbs_s;
	cbs_s st, next_st;
	logic hold_level;

	cbs_sync u_hold_sync (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_hold_req),
		.o_level(hold_level)
	);

	function automatic logic [3:0] cbs_encode(input logic [2:0] kind);
		case (kind)
			cbs_pkg::REQ_INT_ACK: cbs_encode = cbs_pkg::CODE_INT_ACK;
			cbs_pkg::REQ_HALT: cbs_encode = cbs_pkg::CODE_HALT;
			cbs_pkg::REQ_SHUTDOWN: cbs_encode = cbs_pkg::CODE_HALT;
			cbs_pkg::REQ_MEM_READ: cbs_encode = cbs_pkg::CODE_MEM_READ;
			cbs_pkg::REQ_MEM_WRITE: cbs_encode = cbs_pkg::CODE_MEM_WRITE;
			cbs_pkg::REQ_IO_READ: cbs_encode = cbs_pkg::CODE_IO_READ;
			cbs_pkg::REQ_IO_WRITE: cbs_encode = cbs_pkg::CODE_IO_WRITE;
			cbs_pkg::REQ_FETCH: cbs_encode = cbs_pkg::CODE_FETCH;
			default: cbs_encode = cbs_pkg::CODE_IDLE_F;
		endcase
	endfunction : cbs_encode

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.state)
			cbs_pkg::CBS_IDLE: begin
				next_st.code[1:0] = 2'h3;
				if (st.lock_next == 1'b0) begin
					next_st.lock_n = 1'b1;
				end
				// drivers float before grant ack rises
				if (hold_level && st.lock_next == 1'b0) begin
					next_st.oe = 1'b0;
					next_st.state = cbs_pkg::CBS_HELD;
				end else if (i_req) begin
					next_st.code = cbs_encode(i_req_kind);
					// halt versus shutdown on address bit one
					next_st.a1 = (i_req_kind == cbs_pkg::REQ_HALT);
					next_st.mem_io = next_st.code[2];
					// code line follows code bit three
					next_st.cod = next_st.code[3];
					next_st.lock_n = !(i_lock_prefix || i_exchange_instruction ||
						i_descriptor_access || i_req_kind == cbs_pkg::REQ_INT_ACK);
					next_st.lock_next = next_st.lock_n == 1'b0;
					next_st.state = cbs_pkg::CBS_STATUS;
				end
			end
			cbs_pkg::CBS_STATUS: begin
				// status lasts one state, then command phase
				next_st.code[1:0] = 2'h3;
				next_st.state = cbs_pkg::CBS_COMMAND;
			end
			cbs_pkg::CBS_COMMAND: begin
				// wait without limit for ready low
				// ready high adds a wait state
				// ready sampled on clock, no synchroniser
				if (!i_ready_n) begin
					next_st.done = 1'b1;
					// lock_next survives: lock stays low and hold waits until the next cycle is taken
					next_st.state = cbs_pkg::CBS_IDLE;
				end
			end
			cbs_pkg::CBS_HELD: begin
				next_st.grant_ack = hold_level;
				if (!hold_level) begin
					if (!st.grant_ack) begin
						next_st.oe = 1'b1;
						next_st.state = cbs_pkg::CBS_IDLE;
					end
				end
			end
			default: next_st.state = cbs_pkg::CBS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			st.state <= cbs_pkg::CBS_IDLE;
			st.code <= cbs_pkg::CODE_IDLE_F;
			st.mem_io <= cbs_pkg::RST_MEM_IO;
			st.cod <= cbs_pkg::RST_CODE;
			st.a1 <= 1'b0;
			st.lock_n <= 1'b1;
			st.lock_next <= 1'b0;
			st.oe <= 1'b1;
			st.grant_ack <= 1'b0;
			st.done <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// status lines read one when released; code[1:0] is already 11 whenever oe is low
	assign o_cycle_status_hi = st.code[1];
	assign o_cycle_status_lo = st.code[0];
	assign o_cycle_status_oe = st.oe;
	assign o_mem_io = st.mem_io;
	// same timing and hold as memory/io
	assign o_code_or_int_ack = st.cod;
	assign o_mem_io_code_oe = st.oe;
	// lock released high while granted; hold is only taken with lock_n already high
	assign o_lock_n = st.lock_n;
	assign o_lock_oe = st.oe;
	assign o_address_bit_one = st.a1;
	assign o_status_state = st.oe && (st.code[1:0] != 2'h3);
	assign o_bus_grant_ack = st.grant_ack;
	assign o_req_done = st.done;

	a_status_state_len: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_status_state |=> !o_status_state) else $error("status state longer than one");
	a_float_status_high: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_bus_grant_ack |-> o_cycle_status_hi && o_cycle_status_lo && !o_cycle_status_oe) else $error("status not floated");
	a_lock_float_high: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_bus_grant_ack |-> o_lock_n && !o_lock_oe) else $error("lock not floated");
	a_mem_io_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_bus_grant_ack && $past(o_bus_grant_ack) |-> $stable(o_mem_io) && $stable(o_code_or_int_ack))
		else $error("memory/io or code changed while held");
	a_mem_io_value: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_IDLE && i_req && !hold_level |=> o_mem_io == $past(i_req_kind != cbs_pkg::REQ_INT_ACK &&
		i_req_kind != cbs_pkg::REQ_IO_READ && i_req_kind != cbs_pkg::REQ_IO_WRITE))
		else $error("memory/io wrong");
	a_halt_addr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_IDLE && i_req && !hold_level && i_req_kind == cbs_pkg::REQ_SHUTDOWN
		|=> !o_address_bit_one && o_mem_io && !o_code_or_int_ack) else $error("shutdown coding wrong");
	a_intack_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_IDLE && i_req && !hold_level && i_req_kind == cbs_pkg::REQ_INT_ACK
		|=> !o_cycle_status_hi && !o_cycle_status_lo && !o_mem_io && !o_lock_n) else $error("intack coding wrong");
	a_fetch_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_IDLE && i_req && !hold_level && i_req_kind == cbs_pkg::REQ_FETCH
		|=> o_code_or_int_ack && o_mem_io && !o_cycle_status_hi && o_cycle_status_lo) else $error("fetch coding wrong");
	a_ready_ends: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_COMMAND && !i_ready_n |=> o_req_done) else $error("ready did not end cycle");
	a_wait_state: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		st.state == cbs_pkg::CBS_COMMAND && i_ready_n |=> !o_req_done && st.state == cbs_pkg::CBS_COMMAND)
		else $error("wait state missing");
	a_float_first: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		$rose(o_bus_grant_ack) |-> $past(!o_cycle_status_oe)) else $error("ack before float");
	c_mem_read: cover property (@(posedge i_clk) st.state == cbs_pkg::CBS_STATUS && st.code == cbs_pkg::CODE_MEM_READ);
	c_wait: cover property (@(posedge i_clk) st.state == cbs_pkg::CBS_COMMAND && i_ready_n ##1 !i_ready_n);
	c_hold: cover property (@(posedge i_clk) $rose(o_bus_grant_ack));
	c_locked: cover property (@(posedge i_clk) !o_lock_n && o_req_done);
endmodule : cbs_bus_cycle

/* tb/cbs_bus_ctl.sv */
`timescale 1ns/1ps
module cbs_bus_ctl (
	// clock
	input wire logic i_clk,
	// cycle status seen on the bus
	input wire logic i_cycle_status_hi,
	input wire logic i_cycle_status_lo,
	// answer shaping
	input wire logic [1:0] i_waits,
	input wire logic i_force_ready,
	output logic o_ready_n
);
	int cnt;
	bit busy;
	initial begin
		o_ready_n = 1'b1;
		busy = 0;
		cnt = 0;
	end
	always @(negedge i_clk) begin
		o_ready_n <= !i_force_ready;
		if (!(i_cycle_status_hi && i_cycle_status_lo)) begin
			busy = 1;
			cnt = 0;
		end else if (busy) begin
			if (cnt == i_waits) begin
				o_ready_n <= 1'b0;
				busy = 0;
			end
			cnt++;
		end
	end
endmodule : cbs_bus_ctl

/* tb/test_cbs_bus_cycle.sv */
`timescale 1ns/1ps
module test_cbs_bus_cycle;
	logic i_clk = 0, i_reset_n = 0, i_req = 0, i_lock_prefix = 0, i_exchange_instruction = 0;
	logic i_descriptor_access = 0, i_hold_req = 0, i_ready_n, frc = 0;
	logic [2:0] i_req_kind = 3'h0;
	logic [1:0] waits = 2'h0;
	logic o_req_done, o_cycle_status_hi, o_cycle_status_lo, o_cycle_status_oe, o_mem_io, o_code_or_int_ack;
	logic o_mem_io_code_oe, o_lock_n, o_lock_oe, o_address_bit_one, o_status_state, o_bus_grant_ack;
	int fail_count = 0, tests_run = 0, n;
	logic prev_lock = 0;
	cbs_bus_cycle dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(i_req), .i_req_kind(i_req_kind),
		.i_lock_prefix(i_lock_prefix), .i_exchange_instruction(i_exchange_instruction),
		.i_descriptor_access(i_descriptor_access), .o_req_done(o_req_done), .i_ready_n(i_ready_n),
		.i_hold_req(i_hold_req), .o_cycle_status_hi(o_cycle_status_hi), .o_cycle_status_lo(o_cycle_status_lo),
		.o_cycle_status_oe(o_cycle_status_oe), .o_mem_io(o_mem_io), .o_code_or_int_ack(o_code_or_int_ack),
		.o_mem_io_code_oe(o_mem_io_code_oe), .o_lock_n(o_lock_n), .o_lock_oe(o_lock_oe),
		.o_address_bit_one(o_address_bit_one), .o_status_state(o_status_state), .o_bus_grant_ack(o_bus_grant_ack));
	cbs_bus_ctl ctl (.i_clk(i_clk), .i_cycle_status_hi(o_cycle_status_hi), .i_cycle_status_lo(o_cycle_status_lo),
		.i_waits(waits), .i_force_ready(frc), .o_ready_n(i_ready_n));
	initial begin
		forever #20 i_clk = ~i_clk;
	end
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	// 0 status state, 1 cycle done, 2 grant ack, other: status driver enable
	function automatic logic pick(input int sel);
		case (sel)
			0: return o_status_state;
			1: return o_req_done;
			2: return o_bus_grant_ack;
			default: return o_cycle_status_oe;
		endcase
	endfunction : pick
	task automatic wait_for(input int lim, input logic want, input int sel);
		n = 0;
		while (pick(sel) !== want && n < lim) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= lim) begin
			fail_count++;
			results();
		end
	endtask : wait_for
	// kinds: 0 intack, 1 halt, 2 mem rd, 3 mem wr, 4 io rd, 5 io wr, 6 fetch, 7 shutdown
	function automatic logic [3:0] exp_code(input int k);
		case (k)
			0: return 4'h0;
			1, 7: return 4'h4;
			2: return 4'h5;
			3: return 4'h6;
			4: return 4'h9;
			5: return 4'ha;
			default: return 4'hd;
		endcase
	endfunction : exp_code
	task automatic run_cycle(input int k, input logic lk, input logic ex, input logic ds, input logic [1:0] w);
		@(negedge i_clk);
		chk("lock gap", 8'(!prev_lock), 8'(o_lock_n));
		i_req_kind = 3'(k);
		i_lock_prefix = lk;
		i_exchange_instruction = ex;
		i_descriptor_access = ds;
		waits = w;
		i_req = 1'b1;
		@(negedge i_clk);
		wait_for(20, 1'b1, 0);
		i_req = 1'b0;
		prev_lock = lk | ex | ds | (k == 0);
		chk("code", 8'(exp_code(k)), {o_code_or_int_ack, o_mem_io, o_cycle_status_hi, o_cycle_status_lo});
		chk("lock", 8'(!(lk | ex | ds | (k == 0))), 8'(o_lock_n));
		if (k == 1 || k == 7)
			chk("a1", 8'(k == 1), 8'(o_address_bit_one));
		@(negedge i_clk);
		chk("status", 8'h3, {o_cycle_status_hi, o_cycle_status_lo});
		wait_for(30, 1'b1, 1);
		chk("length", 8'(1 + w), 8'(n));
	endtask : run_cycle
	initial begin
		void'($urandom(32'hd8de));
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
		chk("reset", 8'h1c, {o_cycle_status_hi, o_cycle_status_lo, o_lock_n, o_req_done, o_bus_grant_ack});
		for (int i = 0; i < 40; i++)
			run_cycle(i < 8 ? i : $urandom % 8, ($urandom % 5) == 0, ($urandom % 5) == 0, ($urandom % 5) == 0,
				2'($urandom));
		run_cycle(6, 0, 0, 0, 2'h0);
		run_cycle(6, 0, 0, 0, 2'h1);
		@(negedge i_clk);
		i_hold_req = 1'b1;
		frc = 1'b1;
		wait_for(40, 1'b1, 2);
		// request and ready stay active while held to show both are ignored
		i_req = 1'b1;
		chk("oe", 8'h0, {o_cycle_status_oe, o_mem_io_code_oe, o_lock_oe});
		chk("float", 8'h1f, {o_code_or_int_ack, o_mem_io, o_cycle_status_hi, o_cycle_status_lo, o_lock_n});
		repeat (6) begin
			@(negedge i_clk);
			chk("held", 8'h0, {o_status_state, o_req_done});
		end
		i_hold_req = 1'b0;
		i_req = 1'b0;
		frc = 1'b0;
		wait_for(40, 1'b0, 2);
		wait_for(10, 1'b1, 3);
		chk("oe back", 8'h7, {o_cycle_status_oe, o_mem_io_code_oe, o_lock_oe});
		run_cycle(4, 0, 0, 0, 2'h3);
		results();
	end
endmodule : test_cbs_bus_cycle
